// ### design/rhm_host_access.sv
// Purpose: Host command decoder for register space, payload buffer and sleep
// Assumes: SPI mode 0 on pins sampled by REF_CLK; UART 8N1 LSB first
// Notes:   Mode commands other than sleep are handled elsewhere
`timescale 1ns/1ps
`default_nettype none
module rhm_host_access
	import rhm_pkg::*;
#(
	parameter int REG_AW     = rhm_pkg::REG_AW,
	parameter int BAUD_DIV   = rhm_pkg::BAUD_DIV,
	parameter int FIFO_DEPTH = rhm_pkg::FIFO_DEPTH
) (
	input  wire logic                        REF_CLK,
	input  wire logic                        RSTN,
	input  wire logic                        CHIP_SELECT_N,
	input  wire logic                        SPI_SCK,
	input  wire logic                        SPI_MOSI,
	output var  logic                        SPI_MISO,
	output var  logic                        SPI_MISO_OE,
	input  wire logic                        UART_RXD,
	output var  logic                        UART_TXD,
	input  wire logic [rhm_pkg::BYTE_W-1:0]  STATUS_BYTE,
	input  wire logic                        IN_STANDBY,
	input  wire logic                        WAKE_TIMER,
	output var  logic                        SLEEP_ON,
	output var  logic                        RETAIN_DATA_RAM,
	output var  logic                        RETAIN_BUFFER,
	output var  logic                        RETAIN_INSTR_RAM,
	output var  logic                        WAKE_STANDBY,
	output var  logic                        RESET_REQ,
	output var  logic                        WIPE_BUSY
);
	import rhm_pkg::*;

	// Opcode class decoders, used by decoder and memory path
	function automatic logic is_buf(input logic [7:0] opc);
		return (opc == OPC_BUF_WR) || (opc == OPC_BUF_RD);
	endfunction : is_buf

	function automatic logic [15:0] step(input logic [7:0] opc, input logic [15:0] a);
		return is_buf(opc) ? {8'h00, a[7:0] + 8'h01} : a + 16'h0001;
	endfunction : step

	// Pin synchronisers; second stage is the only reader of the first
	logic [3:0] meta_r, sync_r;
	logic       cs_d_r, sck_d_r;
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			meta_r  <= SYNC_IDLE;
			sync_r  <= SYNC_IDLE;
			cs_d_r  <= 1'b1;
			sck_d_r <= 1'b0;
		end else begin
			meta_r  <= {CHIP_SELECT_N, SPI_SCK, SPI_MOSI, UART_RXD};
			sync_r  <= meta_r;
			cs_d_r  <= sync_r[3];
			sck_d_r <= sync_r[2];
		end
	end

	logic cs_s, mosi_s, rxd_s, cs_rise, cs_fall, sck_rise, sck_fall;
	assign cs_s     = sync_r[3];
	assign mosi_s   = sync_r[1];
	assign rxd_s    = sync_r[0];
	assign cs_rise  = ~cs_d_r & cs_s;
	assign cs_fall  = cs_d_r & ~cs_s;
	assign sck_rise = ~sck_d_r & sync_r[2] & ~cs_s;
	assign sck_fall = sck_d_r & ~sync_r[2] & ~cs_s;

	// SPI shifter: sample on rise, drive on fall, never stalls the host
	logic [7:0] srx_r, srx_nxt, stx_r, stx_nxt, ntx_r, spi_byte;
	logic [2:0] bcnt_r, bcnt_nxt;
	logic       spi_byte_v;
	always_comb begin
		srx_nxt    = srx_r;
		stx_nxt    = stx_r;
		bcnt_nxt   = bcnt_r;
		spi_byte_v = 1'b0;
		spi_byte   = {srx_r[6:0], mosi_s};
		if (cs_s) begin
			bcnt_nxt = 3'h0;
		end
		if (cs_fall) begin
			stx_nxt = STATUS_BYTE;
		end else if (sck_rise) begin
			srx_nxt    = spi_byte;
			bcnt_nxt   = bcnt_r + 3'h1;
			spi_byte_v = (bcnt_r == 3'h7);
		end else if (sck_fall) begin
			stx_nxt = (bcnt_r == 3'h0) ? ntx_r : {stx_r[6:0], 1'b0};
		end
	end

	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			srx_r       <= 8'h00;
			stx_r       <= 8'h00;
			bcnt_r      <= 3'h0;
			SPI_MISO    <= 1'b0;
			SPI_MISO_OE <= 1'b0;
		end else begin
			srx_r       <= srx_nxt;
			stx_r       <= stx_nxt;
			bcnt_r      <= bcnt_nxt;
			SPI_MISO    <= stx_nxt[7];
			SPI_MISO_OE <= ~cs_s;
		end
	end

	// UART receiver and transmitter, one bit period per divider wrap
	logic [15:0] urc_r, urc_nxt, utc_r, utc_nxt;
	logic [3:0]  urb_r, urb_nxt, utb_r, utb_nxt;
	logic [7:0]  urs_r, urs_nxt;
	logic [9:0]  uts_r, uts_nxt;
	logic        ura_r, ura_nxt, uta_r, uta_nxt, uart_byte_v;
	logic        f_in_valid, f_in_ready, f_out_valid;
	logic [7:0]  f_out_data, rd_data;
	always_comb begin
		urc_nxt     = urc_r;
		urb_nxt     = urb_r;
		urs_nxt     = urs_r;
		ura_nxt     = ura_r;
		uart_byte_v = 1'b0;
		if (!ura_r) begin
			if (!rxd_s) begin
				ura_nxt = 1'b1;
				urc_nxt = 16'(BAUD_DIV / 2);
				urb_nxt = 4'h0;
			end
		end else if (urc_r == 16'h0000) begin
			urc_nxt = 16'(BAUD_DIV - 1);
			urb_nxt = urb_r + 4'h1;
			if (urb_r == 4'h0) begin
				ura_nxt = ~rxd_s; // Glitch, not a start bit
			end else if (urb_r == 4'(UART_STOP)) begin
				ura_nxt     = 1'b0;
				uart_byte_v = rxd_s;
			end else begin
				urs_nxt = {rxd_s, urs_r[7:1]};
			end
		end else begin
			urc_nxt = urc_r - 16'h0001;
		end
		utc_nxt = utc_r;
		utb_nxt = utb_r;
		uts_nxt = uts_r;
		uta_nxt = uta_r;
		if (!uta_r) begin
			if (f_out_valid) begin
				uta_nxt = 1'b1;
				uts_nxt = {1'b1, f_out_data, 1'b0};
				utc_nxt = 16'(BAUD_DIV - 1);
				utb_nxt = 4'h0;
			end
		end else if (utc_r == 16'h0000) begin
			uts_nxt = {1'b1, uts_r[9:1]};
			utc_nxt = 16'(BAUD_DIV - 1);
			utb_nxt = utb_r + 4'h1;
			uta_nxt = (utb_r != 4'(UART_STOP));
		end else begin
			utc_nxt = utc_r - 16'h0001;
		end
	end

	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			urc_r    <= 16'h0000;
			urb_r    <= 4'h0;
			urs_r    <= 8'h00;
			ura_r    <= 1'b0;
			utc_r    <= 16'h0000;
			utb_r    <= 4'h0;
			uts_r    <= 10'h3ff;
			uta_r    <= 1'b0;
			UART_TXD <= 1'b1;
		end else begin
			urc_r    <= urc_nxt;
			urb_r    <= urb_nxt;
			urs_r    <= urs_nxt;
			ura_r    <= ura_nxt;
			utc_r    <= utc_nxt;
			utb_r    <= utb_nxt;
			uts_r    <= uts_nxt;
			uta_r    <= uta_nxt;
			UART_TXD <= uta_nxt ? uts_nxt[0] : 1'b1;
		end
	end

	// Read bytes queue here so a slow UART stalls only the decoder
	rhm_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_txq (
		.clk       (REF_CLK),
		.rst_n     (RSTN),
		.in_valid  (f_in_valid),
		.in_ready  (f_in_ready),
		.in_data   (rd_data),
		.out_valid (f_out_valid),
		.out_ready (~uta_r),
		.out_data  (f_out_data)
	);

	// Register space and 256-byte circular payload buffer
	logic [7:0]  reg_mem [2**REG_AW];
	logic [7:0]  buf_mem [BUF_DEPTH];
	logic        reg_we, buf_we;
	logic [15:0] w_addr;
	logic [7:0]  w_data;

	// Command decoder state
	rhm_phase_e  ph_r, ph_nxt;
	logic [7:0]  opc_r, opc_nxt, len_r, len_nxt, cfg_r, cfg_nxt, ntx_nxt, swc_r, swc_nxt, b;
	logic [15:0] addr_r, addr_nxt;
	logic        uart_r, uart_nxt, pend_r, pend_nxt, saved_r, saved_nxt;
	logic        sleep_r, sleep_nxt, swp_r, swp_nxt, wake_nxt, rreq_nxt, byte_v;

	assign rd_data = is_buf(opc_r) ? buf_mem[addr_r[7:0]] : reg_mem[addr_r[REG_AW-1:0]];
	assign byte_v  = (spi_byte_v | (uart_byte_v & cs_s)) & ~sleep_r & ~swp_r;
	assign b       = spi_byte_v ? spi_byte : urs_r;

	// Next-state of the decoder, sleep and wipe sweep
	always_comb begin
		ph_nxt = ph_r; opc_nxt = opc_r; len_nxt = len_r; cfg_nxt = cfg_r;
		addr_nxt = addr_r; uart_nxt = uart_r; pend_nxt = pend_r; saved_nxt = saved_r;
		sleep_nxt = sleep_r; swp_nxt = swp_r; swc_nxt = swc_r; ntx_nxt = ntx_r;
		wake_nxt = 1'b0; rreq_nxt = 1'b0; f_in_valid = 1'b0;
		reg_we = 1'b0; buf_we = 1'b0; w_addr = addr_r; w_data = b;
		if (swp_r) begin
			// Flush what was not retained; registers kept only if saved
			reg_we  = ~(cfg_r[RET_DATA_BIT] & saved_r);
			buf_we  = ~cfg_r[RET_BUF_BIT];
			w_addr  = {8'h00, swc_r};
			w_data  = 8'h00;
			swc_nxt = swc_r + 8'h01;
			if (swc_r == 8'hff) begin
				swp_nxt  = 1'b0;
				wake_nxt = 1'b1;
			end
		end else if (sleep_r) begin
			if (cs_rise | WAKE_TIMER) begin
				sleep_nxt = 1'b0;
				swp_nxt   = 1'b1;
				swc_nxt   = 8'h00;
				rreq_nxt  = ~cfg_r[RET_INSTR_BIT];
			end
		end else if (cs_rise) begin
			ph_nxt   = P_OPC;
			pend_nxt = 1'b0;
			sleep_nxt = pend_r & IN_STANDBY;
		end else if (ph_r == P_RD && uart_r) begin
			f_in_valid = 1'b1;
			if (f_in_ready) begin
				addr_nxt = step(opc_r, addr_r);
				len_nxt  = len_r - 8'h01;
				ph_nxt   = (len_r == 8'h01) ? P_OPC : P_RD;
			end
		end else if (byte_v) begin
			ntx_nxt = STATUS_BYTE;
			unique case (ph_r)
				P_OPC: begin
					opc_nxt  = b;
					uart_nxt = ~spi_byte_v;
					addr_nxt = 16'h0000;
					if (b == OPC_REG_WR || b == OPC_REG_RD) begin
						ph_nxt = P_AH;
					end else if (b == OPC_BUF_WR || b == OPC_BUF_RD) begin
						ph_nxt = P_AL;
					end else if (b == OPC_SLEEP) begin
						ph_nxt = P_CFG;
					end else begin
						saved_nxt = saved_r | (b == OPC_STORE);
						ph_nxt    = spi_byte_v ? P_SKIP : P_OPC;
					end
				end
				P_AH: begin
					addr_nxt = {b, 8'h00};
					ph_nxt   = P_AL;
				end
				P_AL: begin
					addr_nxt = {addr_r[15:8], b};
					if (uart_r) begin
						ph_nxt = P_LEN;
					end else begin
						ph_nxt = (opc_r == OPC_REG_WR || opc_r == OPC_BUF_WR) ? P_WR : P_DUM;
					end
				end
				P_LEN: begin
					len_nxt = b;
					if (b == 8'h00) begin
						ph_nxt = P_OPC;
					end else begin
						ph_nxt = (opc_r == OPC_REG_WR || opc_r == OPC_BUF_WR) ? P_WR : P_RD;
					end
				end
				P_DUM, P_RD: begin
					ntx_nxt  = rd_data;
					addr_nxt = step(opc_r, addr_r);
					ph_nxt   = P_RD;
				end
				P_WR: begin
					reg_we   = ~is_buf(opc_r);
					buf_we   = is_buf(opc_r);
					addr_nxt = step(opc_r, addr_r);
					len_nxt  = len_r - 8'h01;
					if (uart_r && len_r == 8'h01) begin
						ph_nxt = P_OPC;
					end
				end
				P_CFG: begin
					cfg_nxt = b;
					pend_nxt = ~uart_r;
					sleep_nxt = uart_r & IN_STANDBY;
					ph_nxt = uart_r ? P_OPC : P_SKIP;
				end
				P_SKIP: begin
					ph_nxt = P_SKIP;
				end
			endcase
		end
	end

	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			ph_r <= P_OPC; opc_r <= 8'h00; len_r <= 8'h00; cfg_r <= RET_RESET;
			addr_r <= 16'h0000; uart_r <= 1'b0; pend_r <= 1'b0; saved_r <= 1'b0;
			sleep_r <= 1'b0; swp_r <= 1'b0; swc_r <= 8'h00; ntx_r <= 8'h00;
			SLEEP_ON <= 1'b0; RETAIN_DATA_RAM <= 1'b0; RETAIN_BUFFER <= 1'b0;
			RETAIN_INSTR_RAM <= 1'b0; WAKE_STANDBY <= 1'b0; RESET_REQ <= 1'b0;
			WIPE_BUSY <= 1'b0;
		end else begin
			ph_r <= ph_nxt; opc_r <= opc_nxt; len_r <= len_nxt; cfg_r <= cfg_nxt;
			addr_r <= addr_nxt; uart_r <= uart_nxt; pend_r <= pend_nxt; saved_r <= saved_nxt;
			sleep_r <= sleep_nxt; swp_r <= swp_nxt; swc_r <= swc_nxt; ntx_r <= ntx_nxt;
			SLEEP_ON <= sleep_nxt;
			RETAIN_DATA_RAM <= sleep_nxt & cfg_nxt[RET_DATA_BIT];
			RETAIN_BUFFER <= sleep_nxt & cfg_nxt[RET_BUF_BIT];
			RETAIN_INSTR_RAM <= sleep_nxt & cfg_nxt[RET_INSTR_BIT];
			WAKE_STANDBY <= wake_nxt;
			RESET_REQ <= rreq_nxt;
			WIPE_BUSY <= swp_nxt;
		end
	end

	// Memory write ports; no reset, contents are software data
	always_ff @(posedge REF_CLK) begin
		if (reg_we) begin
			reg_mem[w_addr[REG_AW-1:0]] <= w_data;
		end
		if (buf_we) begin
			buf_mem[w_addr[7:0]] <= w_data;
		end
	end

	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RSTN);

	a_reg_addr_step: assert property (byte_v && ph_r == P_WR && !is_buf(opc_r)
		|=> addr_r == $past(addr_r) + 16'h0001) else $error("register address did not step");
	a_buf_wrap: assert property (byte_v && ph_r == P_WR && is_buf(opc_r) && addr_r[7:0] == 8'hff
		|=> addr_r[7:0] == 8'h00) else $error("buffer pointer did not wrap");
	a_reg_opcode: assert property (byte_v && ph_r == P_OPC && b == OPC_REG_WR
		|=> ph_r == P_AH ##0 opc_r == OPC_REG_WR) else $error("write opcode not taken");
	a_spi_dummy: assert property (spi_byte_v && byte_v && ph_r == P_AL && opc_r == OPC_REG_RD
		|=> ph_r == P_DUM) else $error("dummy byte phase missing");
	a_status_byte: assert property (spi_byte_v && byte_v && ph_r == P_OPC
		|=> ntx_r == $past(STATUS_BYTE)) else $error("status not queued");
	a_sleep_standby: assert property ($rose(sleep_r) |-> $past(IN_STANDBY))
		else $error("sleep entered outside standby");
	a_sleep_on_cs: assert property (!sleep_r && !swp_r && cs_rise && pend_r && IN_STANDBY
		|=> sleep_r ##1 SLEEP_ON) else $error("sleep not entered at chip select rise");
	a_wake_sweep: assert property (sleep_r && WAKE_TIMER |=> !sleep_r && swp_r ##256 (!swp_r
		&& WAKE_STANDBY)) else $error("wake sequence wrong");
	a_uart_count: assert property (ph_r == P_RD && uart_r && f_in_ready && len_r == 8'h01
		|=> ph_r == P_OPC) else $error("uart read count wrong");

	c_spi_read: cover property (ph_r == P_DUM ##[1:400] ph_r == P_RD);
	// Last counted byte of a UART write closes the command
	c_uart_write: cover property (uart_r && ph_r == P_WR && byte_v && len_r == 8'h01
		##1 ph_r == P_OPC);
	c_sleep_wake: cover property ($rose(sleep_r) ##[1:1000] WAKE_STANDBY);
	c_fifo_full: cover property (f_in_valid && !f_in_ready);
endmodule : rhm_host_access
`default_nettype wire

// ### inc/rhm_pkg.sv
// Purpose: Shared constants and types for the radio host memory access block
// Assumes: 100 MHz core clock; UART 8N1, LSB first
// Notes:   Opcodes, retention bit positions and timing counts live here only
package rhm_pkg;
	// Core clock and UART rate
	localparam int CLK_HZ     = 100_000_000;
	localparam int UART_BAUD  = 115_200;
	localparam int BAUD_DIV   = CLK_HZ / UART_BAUD;
	// Sizes
	localparam int BYTE_W     = 8;
	localparam int REG_AW     = 8;
	localparam int BUF_DEPTH  = 256;
	localparam int FIFO_DEPTH = 16;
	localparam int UART_STOP  = 9;
	// Command opcodes
	localparam logic [7:0] OPC_REG_WR = 8'h18;
	localparam logic [7:0] OPC_REG_RD = 8'h19;
	localparam logic [7:0] OPC_BUF_WR = 8'h1a;
	localparam logic [7:0] OPC_BUF_RD = 8'h1b;
	localparam logic [7:0] OPC_SLEEP  = 8'h84;
	localparam logic [7:0] OPC_STORE  = 8'hd5; // Value is arbitrary
	// Retention byte fields
	localparam int RET_DATA_BIT  = 0;
	localparam int RET_BUF_BIT   = 1;
	localparam int RET_INSTR_BIT = 2;
	localparam logic [7:0] RET_RESET = 8'h00;
	// Synchroniser idle levels {cs_n, sck, mosi, rxd}
	localparam logic [3:0] SYNC_IDLE = 4'h9;
	// Command phases
	typedef enum logic [8:0] {
		P_OPC  = 9'h001,
		P_AH   = 9'h002,
		P_AL   = 9'h004,
		P_LEN  = 9'h008,
		P_DUM  = 9'h010,
		P_WR   = 9'h020,
		P_RD   = 9'h040,
		P_CFG  = 9'h080,
		P_SKIP = 9'h100
	} rhm_phase_e;
endpackage : rhm_pkg

// ### design/rhm_fifo.sv
// Purpose: Byte FIFO between the read path and the UART transmitter
// Assumes: Single clock, valid/ready on both sides
// Notes:   DEPTH must be a power of two
`timescale 1ns/1ps
`default_nettype none
module rhm_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wp_r, wp_nxt, rp_r, rp_nxt;
	logic             push, pop;

	// Extra pointer bit tells full from empty
	always_comb begin
		in_ready  = (wp_r - rp_r) != (AW+1)'(DEPTH);
		out_valid = wp_r != rp_r;
		out_data  = mem[rp_r[AW-1:0]];
		push      = in_valid & in_ready;
		pop       = out_valid & out_ready;
		wp_nxt    = push ? wp_r + 1'b1 : wp_r;
		rp_nxt    = pop ? rp_r + 1'b1 : rp_r;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_r <= '0;
			rp_r <= '0;
		end else begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
		end
	end

	// Storage has no reset; only pointers matter
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wp_r[AW-1:0]] <= in_data;
		end
	end
endmodule : rhm_fifo
`default_nettype wire

// ### verif/rhm_host_model.sv
// Purpose: Host controller model on the SPI and UART ports of the decoder
// Assumes: SPI mode 0 with a 125 ns bit period; UART 8N1 at 16 clocks a bit
// Notes:   The bench calls the frame and byte tasks by hierarchical name
`timescale 1ns/1ps
`default_nettype none
module rhm_host_model (
	input  wire logic ref_clk,
	output logic      chip_select_n,
	output logic      spi_sck,
	output logic      spi_mosi,
	input  wire logic spi_miso,
	input  wire logic spi_miso_oe,
	output logic      uart_rxd,
	input  wire logic uart_txd,
	input  wire logic wipe_busy
);
	logic miso_last;
	// Released data line reads back inverted, never as a lucky match
	wire logic miso_w = spi_miso_oe ? spi_miso : ~miso_last;

	// Idle levels: frame closed, clock parked low, UART line high
	initial begin
		chip_select_n = 1'b1;
		spi_sck = 1'b0;
		spi_mosi = 1'b0;
		uart_rxd = 1'b1;
		miso_last = 1'b0;
	end

	// Track the last level the device drove
	always @(posedge ref_clk) begin
		if (spi_miso_oe === 1'b1)
			miso_last <= spi_miso;
	end

	// Hold off while the device is busy, bounded
	task automatic wait_ready();
		int n;
		n = 0;
		while (wipe_busy !== 1'b0 && n < 2000) begin
			@(posedge ref_clk);
			n++;
		end
	endtask : wait_ready

	// One framed SPI transfer; the clock only runs inside the frame
	task automatic spi_frame(input int n, input logic [7:0] tx [16],
		output logic [7:0] rx [16]);
		wait_ready();
		@(posedge ref_clk);
		#3 chip_select_n = 1'b0;
		#100;
		for (int b = 0; b < n; b++) begin
			for (int i = 7; i >= 0; i--) begin
				spi_mosi = tx[b][i];
				#62.5 spi_sck = 1'b1;
				rx[b][i] = miso_w;
				#62.5 spi_sck = 1'b0;
			end
		end
		#100 chip_select_n = 1'b1;
		spi_mosi = ~spi_mosi;
		#200;
	endtask : spi_frame

	// One UART byte: start, eight bits LSB first, stop
	task automatic uart_tx(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		wait_ready();
		for (int i = 0; i < 10; i++) begin
			@(posedge ref_clk);
			uart_rxd <= f[i];
			repeat (15) @(posedge ref_clk);
		end
	endtask : uart_tx

	// Receive one byte; got is low on timeout or a bad stop bit
	task automatic uart_rx1(output logic [7:0] b, output logic got, input int limit);
		int n;
		n = 0;
		got = 1'b0;
		b = 8'h00;
		while (uart_txd !== 1'b0 && n < limit) begin
			@(posedge ref_clk);
			n++;
		end
		if (uart_txd === 1'b0) begin
			repeat (8) @(posedge ref_clk);
			for (int i = 0; i < 8; i++) begin
				repeat (16) @(posedge ref_clk);
				b[i] = uart_txd;
			end
			repeat (16) @(posedge ref_clk);
			got = (uart_txd === 1'b1);
		end
	endtask : uart_rx1
endmodule : rhm_host_model
`default_nettype wire

// ### verif/radio_host_memory_access_tb_top.sv
// Purpose: Self-checking bench for the host command decoder
// Assumes: Host model on SPI and UART; UART shortened to 16 clocks a bit
// Notes:   Expected bytes come from the data sent and the opcodes
`timescale 1ns/1ps
`default_nettype none
module radio_host_memory_access_tb_top;
	import rhm_pkg::*;
	logic       ref_clk;
	logic       rstn;
	logic       in_standby;
	logic       wake_timer;
	logic [7:0] status_byte;
	logic [7:0] tx [16];
	logic [7:0] rx [16];
	wire logic  cs_n, sck, mosi, miso, miso_oe, rxd, txd;
	wire logic  sleep_on, ret_d, ret_b, ret_i, wake_sb, rst_req, wipe;
	int         num_errors, compares, cycles, wake_cnt, rreq_cnt, wipe_cnt;

	rhm_host_access #(.BAUD_DIV(16)) i_dut (
		.REF_CLK(ref_clk), .RSTN(rstn), .CHIP_SELECT_N(cs_n), .SPI_SCK(sck),
		.SPI_MOSI(mosi), .SPI_MISO(miso), .SPI_MISO_OE(miso_oe), .UART_RXD(rxd),
		.UART_TXD(txd), .STATUS_BYTE(status_byte), .IN_STANDBY(in_standby),
		.WAKE_TIMER(wake_timer), .SLEEP_ON(sleep_on), .RETAIN_DATA_RAM(ret_d),
		.RETAIN_BUFFER(ret_b), .RETAIN_INSTR_RAM(ret_i), .WAKE_STANDBY(wake_sb),
		.RESET_REQ(rst_req), .WIPE_BUSY(wipe));

	rhm_host_model i_host (
		.ref_clk(ref_clk), .chip_select_n(cs_n), .spi_sck(sck), .spi_mosi(mosi),
		.spi_miso(miso), .spi_miso_oe(miso_oe), .uart_rxd(rxd), .uart_txd(txd),
		.wipe_busy(wipe));

	// 100 MHz core clock
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// Pulse widths and the hang limit, counted every cycle
	always @(posedge ref_clk) begin
		cycles++;
		if (wake_sb === 1'b1) wake_cnt++;
		if (rst_req === 1'b1) rreq_cnt++;
		if (wipe === 1'b1) wipe_cnt++;
		if (cycles == 40000) begin
			num_errors++;
			give_verdict();
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic give_verdict();
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : give_verdict

	task automatic spi(input int n);
		i_host.spi_frame(n, tx, rx);
	endtask : spi

	task automatic uart_send(input int n);
		for (int i = 0; i < n; i++) i_host.uart_tx(tx[i]);
	endtask : uart_send

	// Listen from the length byte on; the device answers during its stop bit
	task automatic uart_read(input int n, input int len);
		logic       ok;
		logic [7:0] junk;
		uart_send(n - 1);
		fork
			i_host.uart_tx(tx[n - 1]);
			begin
				for (int i = 0; i < len; i++) begin
					i_host.uart_rx1(rx[i], ok, 2000);
					check(ok, 1'b1);
				end
				i_host.uart_rx1(junk, ok, 600);
				check(ok, 1'b0);
			end
		join
	endtask : uart_read

	// Main sequence
	initial begin
		rstn = 1'b0;
		in_standby = 1'b0;
		wake_timer = 1'b0;
		status_byte = 8'h45;
		repeat (6) @(posedge ref_clk);
		rstn <= 1'b1;
		repeat (5) @(posedge ref_clk);
		// Register write crossing 0x00ff, status on every byte
		tx = '{0:OPC_REG_WR, 1:8'h00, 2:8'hfe, 3:8'h11, 4:8'h22, 5:8'h33, default:8'h00};
		spi(6);
		for (int i = 0; i < 6; i++) check(rx[i], 8'h45);
		tx = '{0:OPC_REG_RD, 1:8'h00, 2:8'hfe, default:8'h00};
		spi(7);
		check(rx[3], 8'h45);
		for (int i = 0; i < 3; i++) check(rx[4 + i], 16'(8'h11 * (i + 1)));
		// Buffer write and read across the 255 to 0 wrap
		tx = '{0:OPC_BUF_WR, 1:8'hfe, 2:8'ha1, 3:8'hb2, 4:8'hc3, default:8'h00};
		spi(5);
		tx = '{0:OPC_BUF_RD, 1:8'hff, default:8'h00};
		spi(5);
		check(rx[2], 8'h45);
		check(rx[3], 8'hb2);
		check(rx[4], 8'hc3);
		// UART register block with length bytes
		tx = '{0:OPC_REG_WR, 1:8'h00, 2:8'h10, 3:8'h02, 4:8'ha5, 5:8'h5a, default:8'h00};
		uart_send(6);
		tx = '{0:OPC_REG_RD, 1:8'h00, 2:8'h10, 3:8'h02, default:8'h00};
		uart_read(4, 2);
		check(rx[0], 8'ha5);
		check(rx[1], 8'h5a);
		tx = '{0:OPC_REG_RD, 1:8'h00, 2:8'h11, default:8'h00};
		spi(5);
		check(rx[4], 8'h5a);
		// UART buffer read over the wrap, UART buffer write read by SPI
		tx = '{0:OPC_BUF_RD, 1:8'hfe, 2:8'h03, default:8'h00};
		uart_read(3, 3);
		check(rx[0], 8'ha1);
		check(rx[1], 8'hb2);
		check(rx[2], 8'hc3);
		tx = '{0:OPC_BUF_WR, 1:8'h40, 2:8'h01, 3:8'h99, default:8'h00};
		uart_send(4);
		tx = '{0:OPC_BUF_RD, 1:8'h40, default:8'h00};
		spi(4);
		check(rx[3], 8'h99);
		// Sleep outside standby is dropped
		tx = '{0:OPC_SLEEP, 1:8'h07, default:8'h00};
		spi(2);
		check(sleep_on, 1'b0);
		// Sleep keeping data RAM only, woken by a frame end
		@(posedge ref_clk);
		in_standby <= 1'b1;
		tx = '{0:OPC_SLEEP, 1:8'h01, default:8'h00};
		spi(2);
		check(sleep_on, 1'b1);
		check({ret_i, ret_b, ret_d}, 3'h1);
		@(posedge ref_clk);
		in_standby <= 1'b0;
		spi(0);
		check(sleep_on, 1'b0);
		check(ret_d, 1'b0);
		i_host.wait_ready();
		repeat (5) @(posedge ref_clk);
		in_standby <= 1'b1;
		check(16'(wake_cnt), 16'h0001);
		check(16'(rreq_cnt), 16'h0001);
		check(16'(wipe_cnt), 16'h0100);
		tx = '{0:OPC_REG_RD, 1:8'h00, 2:8'h10, default:8'h00};
		spi(5);
		check(rx[4], 8'h00);
		tx = '{0:OPC_BUF_RD, 1:8'hfe, default:8'h00};
		spi(4);
		check(rx[3], 8'h00);
		// Saved settings, full retention over UART, woken by the timer
		tx = '{0:OPC_REG_WR, 1:8'h00, 2:8'h10, 3:8'h3c, default:8'h00};
		spi(4);
		tx = '{0:OPC_BUF_WR, 1:8'h20, 2:8'h5e, default:8'h00};
		spi(3);
		tx = '{0:OPC_STORE, default:8'h00};
		spi(1);
		tx = '{0:OPC_SLEEP, 1:8'h07, default:8'h00};
		uart_send(2);
		repeat (10) @(posedge ref_clk);
		check(sleep_on, 1'b1);
		check({ret_i, ret_b, ret_d}, 3'h7);
		in_standby <= 1'b0;
		wake_timer <= 1'b1;
		@(posedge ref_clk);
		wake_timer <= 1'b0;
		repeat (6) @(posedge ref_clk);
		check(sleep_on, 1'b0);
		i_host.wait_ready();
		repeat (5) @(posedge ref_clk);
		in_standby <= 1'b1;
		check(16'(wake_cnt), 16'h0002);
		check(16'(rreq_cnt), 16'h0001);
		tx = '{0:OPC_REG_RD, 1:8'h00, 2:8'h10, default:8'h00};
		spi(5);
		check(rx[4], 8'h3c);
		tx = '{0:OPC_BUF_RD, 1:8'h20, default:8'h00};
		spi(4);
		check(rx[3], 8'h5e);
		give_verdict();
	end
endmodule : radio_host_memory_access_tb_top
`default_nettype wire
